/* core/rlp_pkg.sv */
// Shared constants and types for the LED feedback shell and its host
package rlp_pkg;
	localparam int PWM_BITS = 12;
	localparam logic [11:0] PWM_MAX = 12'hfff;
	localparam int CORE_CLK_PERIOD_NS = 8;
	localparam int RESET_MIN_NS = 10000;
	localparam int RESET_CYCLES = (RESET_MIN_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
	localparam int EE_SCL_PERIOD_NS = 2500;
	localparam int EE_QUARTER_CYCLES =
		(EE_SCL_PERIOD_NS / 4 + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
	localparam int HOST_QUARTER_CYCLES = 8;
	localparam logic [6:0] EEPROM_ADDR = 7'h50;
	localparam logic [6:0] SLAVE_ADDR = 7'h2a;
	localparam logic RW_WRITE = 1'b0;
	localparam logic RW_READ = 1'b1;
	localparam int TARGET_BYTES = 6;
	localparam logic [2:0] TARGET_LAST = 3'h5;
	localparam logic [3:0] LAST_SLOT = 4'h8;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	typedef enum logic [1:0] {
		TWI_START = 2'b00,
		TWI_STOP = 2'b01,
		TWI_WRITE = 2'b10,
		TWI_READ = 2'b11
	} rlp_twi_cmd_t;

	// High byte carries the top nibble of a 12-bit target in its low bits
	function automatic logic [11:0] rlp_join(input logic [7:0] hi, input logic [7:0] lo);
		rlp_join = {hi[3:0], lo};
	endfunction : rlp_join
endpackage : rlp_pkg

/* core/rlp_link_if.sv */
// Host link between the controller and the LED feedback device
`timescale 1ns/1ps
interface rlp_link_if;
	logic global_reset_n;
	logic host_serial_clock;
	logic host_serial_data_out;
	logic host_serial_data_oe_n;
	logic dev_serial_data_out;
	logic dev_serial_data_oe_n;
	logic host_serial_data;

	// Pull-up: the line is low only where an enabled driver drives low
	assign host_serial_data = (host_serial_data_oe_n | host_serial_data_out) &
		(dev_serial_data_oe_n | dev_serial_data_out);

	modport host (
		output global_reset_n,
		output host_serial_clock,
		output host_serial_data_out,
		output host_serial_data_oe_n,
		input host_serial_data
	);
	modport device (
		input global_reset_n,
		input host_serial_clock,
		input host_serial_data,
		output dev_serial_data_out,
		output dev_serial_data_oe_n
	);
endinterface : rlp_link_if

/* core/rlp_twi_master.sv */
// Byte-level two-wire master engine with its own clock divider
`timescale 1ns/1ps
module rlp_twi_master #(
	parameter int QUARTER = 8
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic cmd_valid,
	input wire rlp_pkg::rlp_twi_cmd_t cmd,
	input wire logic [7:0] tx_byte,
	input wire logic tx_ack,
	output logic cmd_ready,
	output logic done,
	output logic [7:0] rx_byte,
	output logic rx_ack,
	output logic scl_out,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic sda_in
);
	localparam int QW = $clog2(QUARTER + 1);
	localparam logic [QW-1:0] QLAST = QW'(QUARTER - 1);

	logic [QW-1:0] qcnt;
	logic tick;
	logic busy;
	rlp_pkg::rlp_twi_cmd_t op;
	logic [1:0] phase;
	logic [3:0] bitn;
	logic [8:0] sh;
	logic sda_m;
	logic sda_s;

	assign tick = busy && (qcnt == QLAST);
	assign cmd_ready = ~busy;
	assign sda_out = 1'b0;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sda_m <= 1'b1;
			sda_s <= 1'b1;
		end else begin
			sda_m <= sda_in;
			sda_s <= sda_m;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			qcnt <= '0;
		end else if (!busy || tick) begin
			qcnt <= '0;
		end else begin
			qcnt <= qcnt + QW'(1);
		end
	end

	// Each bit takes four quarters: set data, raise clock, sample, drop clock
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			busy <= 1'b0;
			op <= rlp_pkg::TWI_STOP;
			phase <= 2'b00;
			bitn <= 4'h0;
			sh <= 9'h1ff;
			scl_out <= 1'b1;
			sda_oe_n <= 1'b1;
			done <= 1'b0;
			rx_byte <= 8'h00;
			rx_ack <= 1'b1;
		end else begin
			done <= 1'b0;
			if (!busy) begin
				if (cmd_valid) begin
					busy <= 1'b1;
					op <= cmd;
					phase <= 2'b00;
					bitn <= 4'h0;
					sh <= (cmd == rlp_pkg::TWI_WRITE) ? {tx_byte, 1'b1} : {8'hff, tx_ack};
				end
			end else if (tick) begin
				phase <= phase + 2'b01;
				case (op)
					rlp_pkg::TWI_START: begin
						case (phase)
							2'b00: sda_oe_n <= 1'b1;
							2'b01: scl_out <= 1'b1;
							2'b10: sda_oe_n <= 1'b0;
							default: begin
								scl_out <= 1'b0;
								busy <= 1'b0;
								done <= 1'b1;
							end
						endcase
					end
					rlp_pkg::TWI_STOP: begin
						case (phase)
							2'b00: sda_oe_n <= 1'b0;
							2'b01: scl_out <= 1'b1;
							2'b10: sda_oe_n <= 1'b1;
							default: begin
								busy <= 1'b0;
								done <= 1'b1;
							end
						endcase
					end
					default: begin
						case (phase)
							2'b00: sda_oe_n <= sh[8];
							2'b01: scl_out <= 1'b1;
							2'b10: sh <= {sh[7:0], sda_s};
							default: begin
								scl_out <= 1'b0;
								if (bitn == rlp_pkg::LAST_SLOT) begin
									busy <= 1'b0;
									done <= 1'b1;
									rx_byte <= sh[8:1];
									rx_ack <= sh[0];
								end else begin
									bitn <= bitn + 4'h1;
								end
							end
						endcase
					end
				endcase
			end
		end
	end
endmodule : rlp_twi_master

/* core/rlp_led_device.sv */
// LED feedback device: host slave port, memory loader and three duty channels
// Operation
// - Three independent 12-bit duty outputs
// - Duty outputs are active high
// - Feedback steps duty toward target colour
// - Async active-low reset clears every register; line samplers, line drivers, memory engine shift register and ack reset high, engine opcode to stop
// - Reset held low at least 10 us
// - Host clocks the link, data two-way
// - Host data line driven low only
// - Device is master on memory link
// - Memory data line open drain
// - Sleep powers down, freezes core logic; reference clock and an in-flight memory command keep running
// - Reference clock at half the core clock rate on dedicated pin
// - Host writes target colour as bytes
// - Memory target address fixed at 0x50
// - Host resets device before any operation
`timescale 1ns/1ps
module rlp_led_device #(
	parameter int EE_QUARTER = rlp_pkg::EE_QUARTER_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset_n,
	rlp_link_if.device link,
	input wire logic [11:0] measured_red,
	input wire logic [11:0] measured_green,
	input wire logic [11:0] measured_blue,
	input wire logic sleep,
	output logic red_pulse_out,
	output logic green_pulse_out,
	output logic blue_pulse_out,
	output logic analog_power_down,
	output logic ref_clock_out,
	output logic eeprom_serial_clock,
	output logic eeprom_serial_data_out,
	output logic eeprom_serial_data_oe_n,
	input wire logic eeprom_serial_data_in,
	output logic target_loaded,
	output logic feedback_running
);
	typedef enum logic [2:0] {
		SLV_IDLE = 3'b000,
		SLV_ADDR = 3'b001,
		SLV_ADDR_ACK = 3'b010,
		SLV_DATA = 3'b011,
		SLV_DATA_ACK = 3'b100
	} rlp_slv_state_t;
	typedef enum logic [2:0] {
		LD_START = 3'b000,
		LD_ADDR = 3'b001,
		LD_READ = 3'b010,
		LD_STOP = 3'b011,
		LD_DONE = 3'b100
	} rlp_load_state_t;

	function automatic logic [11:0] rlp_step(input logic [11:0] duty,
		input logic [11:0] tgt, input logic [11:0] meas);
		if (meas < tgt && duty != rlp_pkg::PWM_MAX) begin
			rlp_step = duty + 12'h001;
		end else if (meas > tgt && duty != 12'h000) begin
			rlp_step = duty - 12'h001;
		end else begin
			rlp_step = duty;
		end
	endfunction : rlp_step

	logic sleep_m, sleep_s, run;
	logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
	logic start_c, stop_c, rise, fall;
	rlp_slv_state_t slv_state;
	logic [3:0] slv_bits;
	logic [7:0] slv_shift;
	logic [7:0] rx_bytes [rlp_pkg::TARGET_BYTES];
	logic [2:0] rx_count;
	logic host_commit;
	rlp_load_state_t ld_state;
	logic ld_wait, ld_ok, ee_commit;
	logic [2:0] ld_count;
	logic [7:0] ee_bytes [rlp_pkg::TARGET_BYTES];
	logic ee_valid, ee_ready, ee_done, ee_rx_ack;
	rlp_pkg::rlp_twi_cmd_t ee_cmd;
	logic [7:0] ee_rx_byte;
	logic [11:0] target [3];
	logic [11:0] duty [3];
	logic [11:0] measured [3];
	logic [11:0] period_cnt;
	logic duty_valid;
	logic [2:0] pulse;

	// Sleep comes from a pin, so it is synchronised before use
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sleep_m <= 1'b0;
			sleep_s <= 1'b0;
			analog_power_down <= 1'b0;
			ref_clock_out <= 1'b0;
		end else begin
			sleep_m <= sleep;
			sleep_s <= sleep_m;
			analog_power_down <= sleep_s;
			ref_clock_out <= ~ref_clock_out;
		end
	end
	// Slave port and duty logic hold their state while asleep
	assign run = ~sleep_s;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_p <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_m <= link.host_serial_clock;
			scl_s <= scl_m;
			scl_p <= scl_s;
			sda_m <= link.host_serial_data;
			sda_s <= sda_m;
			sda_p <= sda_s;
		end
	end
	assign start_c = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_c = scl_s & scl_p & ~sda_p & sda_s;
	assign rise = scl_s & ~scl_p;
	assign fall = ~scl_s & scl_p;
	assign link.dev_serial_data_out = 1'b0;

	// Host slave: write-only, takes six target bytes per frame
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			slv_state <= SLV_IDLE;
			slv_bits <= 4'h0;
			slv_shift <= 8'h00;
			rx_count <= 3'h0;
			host_commit <= 1'b0;
			link.dev_serial_data_oe_n <= 1'b1;
			for (int i = 0; i < rlp_pkg::TARGET_BYTES; i++) begin
				rx_bytes[i] <= 8'h00;
			end
		end else if (run) begin
			host_commit <= 1'b0;
			if (start_c) begin
				slv_state <= SLV_ADDR;
				slv_bits <= 4'h0;
				rx_count <= 3'h0;
				link.dev_serial_data_oe_n <= 1'b1;
			end else if (stop_c) begin
				slv_state <= SLV_IDLE;
				link.dev_serial_data_oe_n <= 1'b1;
			end else begin
				case (slv_state)
					SLV_ADDR, SLV_DATA: begin
						if (rise && slv_bits != rlp_pkg::BYTE_BITS) begin
							slv_shift <= {slv_shift[6:0], sda_s};
							slv_bits <= slv_bits + 4'h1;
						end else if (fall && slv_bits == rlp_pkg::BYTE_BITS) begin
							slv_bits <= 4'h0;
							if (slv_state == SLV_DATA && rx_count <= rlp_pkg::TARGET_LAST) begin
								link.dev_serial_data_oe_n <= 1'b0;
								slv_state <= SLV_DATA_ACK;
								rx_bytes[rx_count] <= slv_shift;
								rx_count <= rx_count + 3'h1;
								host_commit <= (rx_count == rlp_pkg::TARGET_LAST);
							end else if (slv_state == SLV_ADDR &&
								slv_shift == {rlp_pkg::SLAVE_ADDR, rlp_pkg::RW_WRITE}) begin
								link.dev_serial_data_oe_n <= 1'b0;
								slv_state <= SLV_ADDR_ACK;
							end else begin
								slv_state <= SLV_IDLE;
							end
						end
					end
					SLV_ADDR_ACK, SLV_DATA_ACK: begin
						if (fall) begin
							link.dev_serial_data_oe_n <= 1'b1;
							slv_state <= SLV_DATA;
						end
					end
					default: ;
				endcase
			end
		end
	end

	// Memory loader: one current-address read of six bytes after reset
	always_comb begin
		case (ld_state)
			LD_START: ee_cmd = rlp_pkg::TWI_START;
			LD_ADDR: ee_cmd = rlp_pkg::TWI_WRITE;
			LD_READ: ee_cmd = rlp_pkg::TWI_READ;
			default: ee_cmd = rlp_pkg::TWI_STOP;
		endcase
	end
	assign ee_valid = run & ~ld_wait & ee_ready & (ld_state != LD_DONE);

	// Not gated by sleep: a command in flight must still see its completion
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ld_state <= LD_START;
			ld_wait <= 1'b0;
			ld_ok <= 1'b0;
			ld_count <= 3'h0;
			ee_commit <= 1'b0;
			for (int i = 0; i < rlp_pkg::TARGET_BYTES; i++) begin
				ee_bytes[i] <= 8'h00;
			end
		end else begin
			ee_commit <= 1'b0;
			if (ee_valid) begin
				ld_wait <= 1'b1;
			end else if (ld_wait && ee_done) begin
				ld_wait <= 1'b0;
				case (ld_state)
					LD_START: ld_state <= LD_ADDR;
					LD_ADDR: ld_state <= ee_rx_ack ? LD_STOP : LD_READ;
					LD_READ: begin
						ee_bytes[ld_count] <= ee_rx_byte;
						ld_count <= ld_count + 3'h1;
						if (ld_count == rlp_pkg::TARGET_LAST) begin
							ld_state <= LD_STOP;
							ld_ok <= 1'b1;
						end
					end
					LD_STOP: begin
						ld_state <= LD_DONE;
						ee_commit <= ld_ok;
					end
					default: ;
				endcase
			end
		end
	end

	rlp_twi_master #(.QUARTER(EE_QUARTER)) u_eeprom_master (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.cmd_valid(ee_valid),
		.cmd(ee_cmd),
		.tx_byte({rlp_pkg::EEPROM_ADDR, rlp_pkg::RW_READ}),
		.tx_ack(ld_count == rlp_pkg::TARGET_LAST),
		.cmd_ready(ee_ready),
		.done(ee_done),
		.rx_byte(ee_rx_byte),
		.rx_ack(ee_rx_ack),
		.scl_out(eeprom_serial_clock),
		.sda_out(eeprom_serial_data_out),
		.sda_oe_n(eeprom_serial_data_oe_n),
		.sda_in(eeprom_serial_data_in)
	);

	assign measured[0] = measured_red;
	assign measured[1] = measured_green;
	assign measured[2] = measured_blue;

	// Target: a host write wins over a memory load in the same cycle
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			target_loaded <= 1'b0;
			for (int c = 0; c < 3; c++) begin
				target[c] <= 12'h000;
			end
		end else if (host_commit || ee_commit) begin
			target_loaded <= 1'b1;
			for (int c = 0; c < 3; c++) begin
				target[c] <= host_commit ?
					rlp_pkg::rlp_join(rx_bytes[2 * c], rx_bytes[2 * c + 1]) :
					rlp_pkg::rlp_join(ee_bytes[2 * c], ee_bytes[2 * c + 1]);
			end
		end
	end

	// Duty starts at the target as an open-loop guess, then tracks the sensor
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			period_cnt <= 12'h000;
			duty_valid <= 1'b0;
			pulse <= 3'b000;
			for (int c = 0; c < 3; c++) begin
				duty[c] <= 12'h000;
			end
		end else if (run) begin
			period_cnt <= period_cnt + 12'h001;
			if (period_cnt == rlp_pkg::PWM_MAX && target_loaded) begin
				duty_valid <= 1'b1;
				for (int c = 0; c < 3; c++) begin
					duty[c] <= duty_valid ? rlp_step(duty[c], target[c], measured[c]) :
						target[c];
				end
			end
			for (int c = 0; c < 3; c++) begin
				pulse[c] <= duty_valid && (period_cnt < duty[c]);
			end
		end
	end
	assign red_pulse_out = pulse[0];
	assign green_pulse_out = pulse[1];
	assign blue_pulse_out = pulse[2];
	assign feedback_running = duty_valid & run;
endmodule : rlp_led_device

/* core/rlp_led_host.sv */
// Host controller end: resets the device and writes target colours
`timescale 1ns/1ps
module rlp_led_host #(
	parameter int QUARTER = rlp_pkg::HOST_QUARTER_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset_n,
	rlp_link_if.host link,
	input wire logic write_valid,
	input wire logic [11:0] red_target,
	input wire logic [11:0] green_target,
	input wire logic [11:0] blue_target,
	output logic write_ready,
	output logic write_done,
	output logic write_nack,
	output logic device_in_reset
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_START = 3'b001,
		H_ADDR = 3'b010,
		H_DATA = 3'b011,
		H_STOP = 3'b100
	} rlp_host_state_t;

	logic [10:0] rst_cnt;
	rlp_host_state_t h_state;
	logic h_wait;
	logic [2:0] idx;
	logic [7:0] bytes [rlp_pkg::TARGET_BYTES];
	logic eng_valid, eng_ready, eng_done, eng_ack;
	rlp_pkg::rlp_twi_cmd_t eng_cmd;
	logic [7:0] eng_tx;

	// Device reset held for the minimum pulse before any traffic
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_cnt <= 11'h000;
			link.global_reset_n <= 1'b0;
		end else if (rst_cnt != 11'(rlp_pkg::RESET_CYCLES)) begin
			rst_cnt <= rst_cnt + 11'h001;
		end else begin
			link.global_reset_n <= 1'b1;
		end
	end
	assign device_in_reset = ~link.global_reset_n;
	assign write_ready = link.global_reset_n & (h_state == H_IDLE);

	always_comb begin
		case (h_state)
			H_START: eng_cmd = rlp_pkg::TWI_START;
			H_ADDR, H_DATA: eng_cmd = rlp_pkg::TWI_WRITE;
			default: eng_cmd = rlp_pkg::TWI_STOP;
		endcase
	end
	assign eng_tx = (h_state == H_ADDR) ? {rlp_pkg::SLAVE_ADDR, rlp_pkg::RW_WRITE} : bytes[idx];
	assign eng_valid = ~h_wait & eng_ready & (h_state != H_IDLE);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			h_state <= H_IDLE;
			h_wait <= 1'b0;
			idx <= 3'h0;
			write_done <= 1'b0;
			write_nack <= 1'b0;
			for (int i = 0; i < rlp_pkg::TARGET_BYTES; i++) begin
				bytes[i] <= 8'h00;
			end
		end else begin
			write_done <= 1'b0;
			if (write_valid && write_ready) begin
				// Each 12-bit target goes as top nibble byte, then low byte
				bytes[0] <= {4'h0, red_target[11:8]};
				bytes[1] <= red_target[7:0];
				bytes[2] <= {4'h0, green_target[11:8]};
				bytes[3] <= green_target[7:0];
				bytes[4] <= {4'h0, blue_target[11:8]};
				bytes[5] <= blue_target[7:0];
				idx <= 3'h0;
				write_nack <= 1'b0;
				h_state <= H_START;
			end else if (eng_valid) begin
				h_wait <= 1'b1;
			end else if (h_wait && eng_done) begin
				h_wait <= 1'b0;
				case (h_state)
					H_START: h_state <= H_ADDR;
					H_ADDR, H_DATA: begin
						if (eng_ack) begin
							write_nack <= 1'b1;
							h_state <= H_STOP;
						end else if (h_state == H_ADDR) begin
							h_state <= H_DATA;
						end else if (idx == rlp_pkg::TARGET_LAST) begin
							h_state <= H_STOP;
						end else begin
							idx <= idx + 3'h1;
						end
					end
					H_STOP: begin
						h_state <= H_IDLE;
						write_done <= 1'b1;
					end
					default: h_state <= H_IDLE;
				endcase
			end
		end
	end

	rlp_twi_master #(.QUARTER(QUARTER)) u_link_master (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.cmd_valid(eng_valid),
		.cmd(eng_cmd),
		.tx_byte(eng_tx),
		.tx_ack(1'b1),
		.cmd_ready(eng_ready),
		.done(eng_done),
		.rx_byte(),
		.rx_ack(eng_ack),
		.scl_out(link.host_serial_clock),
		.sda_out(link.host_serial_data_out),
		.sda_oe_n(link.host_serial_data_oe_n),
		.sda_in(link.host_serial_data)
	);
endmodule : rlp_led_host

/* verif/rlp_link_monitor.sv */
// Protocol checker for the host-side two-wire link
`timescale 1ns/1ps
module rlp_link_monitor (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic global_reset_n,
	input wire logic host_serial_clock,
	input wire logic host_serial_data_out,
	input wire logic host_serial_data_oe_n,
	input wire logic dev_serial_data_out,
	input wire logic dev_serial_data_oe_n,
	input wire logic host_serial_data
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	// Acknowledge: pulled in the low phase, then held low for at least eight core cycles
	sequence ack_pulled;
		$fell(dev_serial_data_oe_n);
	endsequence
	sequence ack_held;
		!dev_serial_data_oe_n [*8];
	endsequence

	chk_dev_low_only: assert property (
		!dev_serial_data_oe_n |-> !dev_serial_data_out && !host_serial_data)
		else $error("device drives link data high");
	chk_host_low_only: assert property (
		!host_serial_data_oe_n |-> !host_serial_data_out && !host_serial_data)
		else $error("host drives link data high");
	chk_line_pulled_up: assert property (
		host_serial_data_oe_n && dev_serial_data_oe_n |-> host_serial_data)
		else $error("released link data not high");
	chk_reset_releases: assert property (
		!global_reset_n |-> dev_serial_data_oe_n)
		else $error("device drives link while in reset");
	chk_clock_idle_reset: assert property (
		!global_reset_n |-> host_serial_clock)
		else $error("link clock not idle during device reset");
	chk_ack_in_low: assert property (
		ack_pulled |-> !host_serial_clock)
		else $error("acknowledge pulled while clock high");
	chk_ack_held: assert property (
		ack_pulled |-> ack_held)
		else $error("acknowledge dropped too early");
	chk_ack_sees_clock: assert property (
		ack_pulled |-> ##[1:40] $rose(host_serial_clock))
		else $error("no clock rise during acknowledge");
	chk_ack_release_low: assert property (
		$rose(dev_serial_data_oe_n) |-> !host_serial_clock)
		else $error("acknowledge released while clock high");
	chk_stable_clock_high: assert property (
		host_serial_clock && $past(host_serial_clock) |-> $stable(dev_serial_data_oe_n))
		else $error("device data changed while clock high");
endmodule : rlp_link_monitor

/* verif/tb.sv */
// Bench joining the LED device and its host across the link
`timescale 1ns/1ps
module tb;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic write_valid = 1'b0;
	logic sleep = 1'b0;
	logic [11:0] rt = 12'h000, gt = 12'h000, bt = 12'h000;
	logic [11:0] mr = 12'h123, mg = 12'h800, mb = 12'hfff;
	logic pr, pg, pb, write_ready, write_done, write_nack, device_in_reset;
	logic analog_power_down, ref_clock_out, ee_clk, ee_out, ee_oe_n, ee_line;
	logic target_loaded, feedback_running, prev;
	logic [8:0] bits;
	int err_total = 0;
	int checked = 0;
	int hr, hg, hb;

	// Pull-up on the memory line; no memory answers, so the address is refused
	assign ee_line = ee_oe_n | ee_out;
	always #4 core_clk = ~core_clk;

	rlp_link_if u_rlp_link_if ();
	rlp_led_host #(.QUARTER(8)) u_rlp_led_host (.core_clk(core_clk), .reset_n(reset_n),
		.link(u_rlp_link_if), .write_valid(write_valid), .red_target(rt), .green_target(gt),
		.blue_target(bt), .write_ready(write_ready), .write_done(write_done),
		.write_nack(write_nack), .device_in_reset(device_in_reset));
	rlp_led_device #(.EE_QUARTER(6)) u_rlp_led_device (.core_clk(core_clk),
		.reset_n(u_rlp_link_if.global_reset_n), .link(u_rlp_link_if), .measured_red(mr),
		.measured_green(mg), .measured_blue(mb), .sleep(sleep), .red_pulse_out(pr),
		.green_pulse_out(pg), .blue_pulse_out(pb), .analog_power_down(analog_power_down),
		.ref_clock_out(ref_clock_out), .eeprom_serial_clock(ee_clk),
		.eeprom_serial_data_out(ee_out), .eeprom_serial_data_oe_n(ee_oe_n),
		.eeprom_serial_data_in(ee_line), .target_loaded(target_loaded),
		.feedback_running(feedback_running));
	rlp_link_monitor u_rlp_link_monitor (.core_clk(core_clk), .reset_n(reset_n),
		.global_reset_n(u_rlp_link_if.global_reset_n),
		.host_serial_clock(u_rlp_link_if.host_serial_clock),
		.host_serial_data_out(u_rlp_link_if.host_serial_data_out),
		.host_serial_data_oe_n(u_rlp_link_if.host_serial_data_oe_n),
		.dev_serial_data_out(u_rlp_link_if.dev_serial_data_out),
		.dev_serial_data_oe_n(u_rlp_link_if.dev_serial_data_oe_n),
		.host_serial_data(u_rlp_link_if.host_serial_data));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize

	function automatic logic pick(input int s);
		case (s)
			0: return write_ready;
			1: return write_done;
			default: return feedback_running;
		endcase
	endfunction : pick

	// Bounded wait; a pulse is seen because each edge is looked at once
	task automatic wait_hi(input int s, input string what);
		int n;
		n = 0;
		while (pick(s) !== 1'b1 && n < 6000) begin
			@(negedge core_clk);
			n++;
		end
		chk(pick(s), 1'b1, what);
	endtask : wait_hi

	// Collects the data level at each rising serial clock, newest bit last
	task automatic get_bits(input logic mem, input int n, output logic [8:0] v);
		logic p;
		logic c;
		v = '0;
		p = mem ? ee_clk : u_rlp_link_if.host_serial_clock;
		for (int i = 0; i < n; ) begin
			@(negedge core_clk);
			c = mem ? ee_clk : u_rlp_link_if.host_serial_clock;
			if (c === 1'b1 && p === 1'b0) begin
				v = {v[7:0], mem ? ee_line : u_rlp_link_if.host_serial_data};
				i++;
			end
			p = c;
		end
	endtask : get_bits

	task automatic host_write(input logic [11:0] r, input logic [11:0] g, input logic [11:0] b);
		@(negedge core_clk);
		rt = r;
		gt = g;
		bt = b;
		write_valid = 1'b1;
		wait_hi(0, "write ready");
		@(negedge core_clk);
		write_valid = 1'b0;
		wait_hi(1, "write done");
	endtask : host_write

	// One whole period, so the count equals the duty
	task automatic count_duty();
		hr = 0;
		hg = 0;
		hb = 0;
		repeat (4096) begin
			@(negedge core_clk);
			if (pr === 1'b1) hr++;
			if (pg === 1'b1) hg++;
			if (pb === 1'b1) hb++;
		end
	endtask : count_duty

	initial begin
		#(60000 * 8);
		err_total++;
		$display("CHECK FAILED at %0t: run hung", $time);
		summarize();
	end

	initial begin
		repeat (5) @(negedge core_clk);
		reset_n = 1'b1;
		chk(device_in_reset, 1'b1, "device held in reset");
		chk({pr, pg, pb}, 3'b000, "duty outputs in reset");
		chk({ee_clk, ee_oe_n, ref_clock_out}, 3'b110, "memory link idle");
		$display("test reset state done");

		wait_hi(0, "device released");
		chk($time / 8 >= rlp_pkg::RESET_CYCLES, 1'b1, "reset pulse width");
		get_bits(1'b1, 9, bits);
		chk(bits, {rlp_pkg::EEPROM_ADDR, rlp_pkg::RW_READ, 1'b1}, "memory address");
		repeat (60) @(negedge core_clk);
		chk({ee_clk, ee_oe_n, target_loaded, pr}, 4'b1100, "refused load");
		prev = ref_clock_out;
		@(negedge core_clk);
		chk(ref_clock_out, !prev, "reference clock toggles");
		$display("test memory load done");

		fork
			host_write(12'h123, 12'h800, 12'hfff);
			get_bits(1'b0, 9, bits);
		join
		chk(bits, {rlp_pkg::SLAVE_ADDR, rlp_pkg::RW_WRITE, 1'b0}, "host address");
		chk({write_nack, target_loaded}, 2'b01, "target taken");
		wait_hi(2, "feedback running");
		count_duty();
		chk(hr, 32'h0000_0123, "red duty");
		chk(hg, 32'h0000_0800, "green duty");
		chk(hb, 32'h0000_0fff, "blue duty");
		$display("test target write done");

		// Red reads dim, so its duty must climb one step per period
		mr = 12'h000;
		repeat (8192) @(negedge core_clk);
		count_duty();
		chk(hr >= 32'h0000_0125, 1'b1, "red duty climbs");
		chk(hb, 32'h0000_0fff, "blue duty holds");
		$display("test feedback done");

		sleep = 1'b1;
		repeat (4) @(negedge core_clk);
		chk({analog_power_down, feedback_running}, 2'b10, "asleep");
		prev = pr;
		hr = 0;
		repeat (300) begin
			@(negedge core_clk);
			if (pr !== prev) hr++;
		end
		chk(hr, 32'h0000_0000, "outputs frozen");
		host_write(12'h200, 12'h200, 12'h200);
		chk(write_nack, 1'b1, "sleeping link refuses");
		sleep = 1'b0;
		host_write(12'h123, 12'h800, 12'hfff);
		chk(write_nack, 1'b0, "write after wake");
		$display("test sleep done");

		@(negedge core_clk);
		reset_n = 1'b0;
		#1;
		chk({pb, target_loaded, feedback_running, u_rlp_link_if.global_reset_n}, 4'b0000,
			"mid-run reset");
		$display("test mid-run reset done");
		summarize();
	end
endmodule : tb
